// file: design/rvi_reset_init.sv
`timescale 1ns/1ps
`include "rvi_params.svh"

module rvi_reset_init #(
  parameter bit HAS_CONVERTER = 1'b1
) (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic SRST_IN,
  // Reset cause strobes from the reset logic
  input wire rvi_pkg::rvi_cause_in_s CAUSE_IN,
  // APB slave
  input wire rvi_pkg::rvi_apb_req_s APB_REQ_IN,
  output rvi_pkg::rvi_apb_rsp_s APB_RSP_OUT,
  // Register contents and program counter load
  output rvi_pkg::rvi_regs_t REGS_OUT,
  output logic PC_LOAD_OUT,
  output logic [12:0] PC_TARGET_OUT
);

  ////////////////////////////////////////////////////////////////////////
  // Per-register attributes

  function automatic rvi_pkg::rvi_attr_s reg_attr(input logic [5:0] idx);
    rvi_pkg::rvi_attr_s a;
    a.mask = `RVI_MASK_FULL;
    a.value = `RVI_VAL_ZERO;
    a.kind = rvi_pkg::KIND_NORM;
    case (idx)
      `RVI_IDX_PC_HIGH_LATCH: begin
        a.mask = `RVI_MASK_PC_HIGH;
      end
      `RVI_IDX_PERIPH_INT_FLAGS, `RVI_IDX_PERIPH_INT_ENABLES: begin
        // Without the converter its flag and enable bit never set
        a.mask = HAS_CONVERTER ? `RVI_MASK_FULL : `RVI_MASK_NO_CONV;
      end
      `RVI_IDX_TIMER_A_COUNT_LOW, `RVI_IDX_TIMER_A_COUNT_HIGH: begin
        a.kind = rvi_pkg::KIND_KEEP;
      end
      `RVI_IDX_TIMER_A_CONTROL: begin
        a.mask = `RVI_MASK_SIX;
        a.kind = rvi_pkg::KIND_POR_ONLY;
      end
      `RVI_IDX_TIMER_B_CONTROL: begin
        a.mask = `RVI_MASK_SEVEN;
      end
      `RVI_IDX_TIMER_B_PERIOD: begin
        a.value = `RVI_VAL_ONES;
        a.kind = rvi_pkg::KIND_FORCE;
      end
      `RVI_IDX_CORE_OPTION: begin
        a.value = `RVI_VAL_ONES;
      end
      `RVI_IDX_PORT_A_DIRECTION, `RVI_IDX_PORT_C_DIRECTION: begin
        a.mask = `RVI_MASK_SIX;
        a.value = `RVI_VAL_ONES;
      end
      `RVI_IDX_PORT_B_DIRECTION, `RVI_IDX_PORT_D_DIRECTION,
      `RVI_IDX_PORT_E_DIRECTION, `RVI_IDX_PORT_F_DIRECTION,
      `RVI_IDX_PORT_G_DIRECTION: begin
        a.value = `RVI_VAL_ONES;
      end
      `RVI_IDX_CAPCMP_CONTROL: begin
        a.mask = `RVI_MASK_SIX;
      end
      `RVI_IDX_CONVERTER_CONTROL_A: begin
        a.mask = `RVI_MASK_CONV_A;
      end
      `RVI_IDX_CONVERTER_CONTROL_B: begin
        a.mask = `RVI_MASK_CONV_B;
      end
      `RVI_IDX_POWER_CONTROL_REG: begin
        a.mask = `RVI_MASK_POWER;
        a.kind = rvi_pkg::KIND_POR_ONLY;
      end
      `RVI_IDX_DISPLAY_SEGMENT_ENABLE: begin
        a.value = `RVI_VAL_ONES;
      end
      `RVI_IDX_DISPLAY_FRAME_PRESCALE: begin
        a.mask = `RVI_MASK_PRESCALE;
      end
      `RVI_IDX_DISPLAY_CONTROL: begin
        a.mask = `RVI_MASK_DISPLAY;
      end
      default: begin
      end
    endcase
    a.value = a.value & a.mask;
    return a;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State and decode

  rvi_pkg::rvi_state_s st_ff;
  rvi_pkg::rvi_state_s nxt_st;

  logic por;
  logic ext;
  logic wake;
  logic any_rst;
  logic acc;
  logic hit;
  logic wr_go;
  logic [5:0] idx;
  logic [31:0] rdata;

  // Block reset behaves as a power-on reset for the registers
  assign por = CAUSE_IN.por || SRST_IN;
  assign ext = CAUSE_IN.ext_rst && !por;
  assign wake = CAUSE_IN.wake && !por && !CAUSE_IN.ext_rst;
  assign any_rst = por || ext || wake;

  assign acc = APB_REQ_IN.psel && APB_REQ_IN.penable;
  assign idx = APB_REQ_IN.paddr[7:2];
  assign hit = (APB_REQ_IN.paddr[11:8] == 4'h0) &&
               (APB_REQ_IN.paddr[1:0] == 2'h0) &&
               (idx <= `RVI_IDX_LAST);
  // A write that meets a cause strobe is dropped: the strobe owns the cycle
  assign wr_go = acc && st_ff.rsp.pready && APB_REQ_IN.pwrite && hit &&
                 (idx != `RVI_IDX_RESET_CAUSE) && !any_rst;

  // Stored values are always masked, so unimplemented bits read zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit) begin
      if (idx == `RVI_IDX_RESET_CAUSE) begin
        rdata = {30'h0000_0000, st_ff.cause};
      end else begin
        rdata = {24'h00_0000, st_ff.regs[idx[4:0]]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    rvi_pkg::rvi_attr_s at;
    at = '0;
    nxt_st = st_ff;
    nxt_st.rsp.pready = 1'b0;
    nxt_st.rsp.pslverr = 1'b0;
    nxt_st.pc_load = 1'b0;

    // Answer one cycle into the access phase
    if (acc && !st_ff.rsp.pready) begin
      nxt_st.rsp.pready = 1'b1;
      nxt_st.rsp.prdata = rdata;
      nxt_st.rsp.pslverr = !hit;
    end

    if (wr_go) begin
      at = reg_attr(idx);
      nxt_st.regs[idx[4:0]] = APB_REQ_IN.pwdata[7:0] & at.mask;
    end

    // Values applied at the edge that samples the strobe
    for (int i = 0; i < 32; i++) begin
      at = reg_attr(6'(i));
      case (at.kind)
        rvi_pkg::KIND_NORM: begin
          if (por || ext) begin
            nxt_st.regs[i] = at.value;
          end
        end
        rvi_pkg::KIND_POR_ONLY: begin
          if (por) begin
            nxt_st.regs[i] = at.value;
          end
        end
        rvi_pkg::KIND_FORCE: begin
          if (any_rst) begin
            nxt_st.regs[i] = at.value;
          end
        end
        default: begin
        end
      endcase
    end

    // Lowest bit of the core interrupt control survives external reset
    if (ext) begin
      nxt_st.regs[`RVI_IDX_CORE_INT_CONTROL][0] =
        st_ff.regs[`RVI_IDX_CORE_INT_CONTROL][0];
    end

    // Wake source flags, OR-ed into the held value; wr_go is low on a wake, so no write competes
    if (wake) begin
      nxt_st.regs[`RVI_IDX_CORE_INT_CONTROL] =
        nxt_st.regs[`RVI_IDX_CORE_INT_CONTROL] |
        CAUSE_IN.core_flags;
      at = reg_attr(`RVI_IDX_PERIPH_INT_FLAGS);
      nxt_st.regs[`RVI_IDX_PERIPH_INT_FLAGS] =
        nxt_st.regs[`RVI_IDX_PERIPH_INT_FLAGS] |
        (CAUSE_IN.periph_flags & at.mask);
    end

    // Program counter steering
    if (por || ext) begin
      nxt_st.pc_load = 1'b1;
      nxt_st.pc_target = `RVI_RESET_VECTOR;
    end else if (wake && CAUSE_IN.wake_by_int &&
                 st_ff.regs[`RVI_IDX_CORE_INT_CONTROL]
                   [`RVI_GLB_INT_EN_BIT]) begin
      nxt_st.pc_load = 1'b1;
      nxt_st.pc_target = `RVI_INT_VECTOR;
    end

    if (por) begin
      nxt_st.cause = rvi_pkg::CAUSE_POR;
    end else if (ext) begin
      nxt_st.cause = rvi_pkg::CAUSE_EXT;
    end else if (wake) begin
      nxt_st.cause = rvi_pkg::CAUSE_WAKE;
    end

    // Block reset also defines the bus answer and the undefined counts
    if (SRST_IN) begin
      nxt_st.rsp = '0;
      nxt_st.cause = rvi_pkg::CAUSE_NONE;
      nxt_st.pc_load = 1'b0;
      nxt_st.pc_target = `RVI_RESET_VECTOR;
      nxt_st.regs[`RVI_IDX_TIMER_A_COUNT_LOW] = `RVI_VAL_ZERO;
      nxt_st.regs[`RVI_IDX_TIMER_A_COUNT_HIGH] = `RVI_VAL_ZERO;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    st_ff <= nxt_st;
  end

  assign APB_RSP_OUT = st_ff.rsp;
  assign REGS_OUT = st_ff.regs;
  assign PC_LOAD_OUT = st_ff.pc_load;
  assign PC_TARGET_OUT = st_ff.pc_target;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (SRST_IN);

  property p_ports_clear;
    (CAUSE_IN.por || CAUSE_IN.ext_rst) |=>
      REGS_OUT[`RVI_IDX_PORT_D_LATCH] == `RVI_VAL_ZERO &&
      REGS_OUT[`RVI_IDX_PORT_G_LATCH] == `RVI_VAL_ZERO;
  endproperty
  a_ports_clear: assert property (p_ports_clear)
    else $error("port latch not cleared by reset");

  property p_pch_keep;
    (CAUSE_IN.wake && !CAUSE_IN.por && !CAUSE_IN.ext_rst) |=>
      REGS_OUT[`RVI_IDX_PC_HIGH_LATCH] ==
      $past(REGS_OUT[`RVI_IDX_PC_HIGH_LATCH]);
  endproperty
  a_pch_keep: assert property (p_pch_keep)
    else $error("pc high latch changed on wake");

  property p_cint_ext;
    (CAUSE_IN.ext_rst && !CAUSE_IN.por) |=>
      REGS_OUT[`RVI_IDX_CORE_INT_CONTROL][7:1] == 7'h00 &&
      REGS_OUT[`RVI_IDX_CORE_INT_CONTROL][0] ==
      $past(REGS_OUT[`RVI_IDX_CORE_INT_CONTROL][0]);
  endproperty
  a_cint_ext: assert property (p_cint_ext)
    else $error("core int control wrong after external reset");

  property p_tactl_ext;
    (CAUSE_IN.ext_rst && !CAUSE_IN.por) |=>
      $stable(REGS_OUT[`RVI_IDX_TIMER_A_CONTROL]) &&
      $stable(REGS_OUT[`RVI_IDX_TIMER_A_COUNT_LOW]);
  endproperty
  a_tactl_ext: assert property (p_tactl_ext)
    else $error("timer A changed on external reset");

  property p_period_force;
    (CAUSE_IN.wake || CAUSE_IN.por || CAUSE_IN.ext_rst) |=>
      REGS_OUT[`RVI_IDX_TIMER_B_PERIOD] == `RVI_VAL_ONES;
  endproperty
  a_period_force: assert property (p_period_force)
    else $error("timer B period not forced to ones");

  property p_dir_inputs;
    (CAUSE_IN.por || CAUSE_IN.ext_rst) |=>
      REGS_OUT[`RVI_IDX_PORT_A_DIRECTION] == `RVI_MASK_SIX &&
      REGS_OUT[`RVI_IDX_PORT_B_DIRECTION] == `RVI_VAL_ONES;
  endproperty
  a_dir_inputs: assert property (p_dir_inputs)
    else $error("port direction not set to inputs");

  property p_power_status;
    CAUSE_IN.por |=>
      REGS_OUT[`RVI_IDX_POWER_CONTROL_REG] == `RVI_VAL_ZERO;
  endproperty
  a_power_status: assert property (p_power_status)
    else $error("power status bit not cleared by power-on");

  property p_wake_flags;
    (CAUSE_IN.wake && !CAUSE_IN.por && !CAUSE_IN.ext_rst) |=>
      (REGS_OUT[`RVI_IDX_CORE_INT_CONTROL] & $past(CAUSE_IN.core_flags))
      == $past(CAUSE_IN.core_flags);
  endproperty
  a_wake_flags: assert property (p_wake_flags)
    else $error("wake source flag not set");

  property p_int_vector;
    (CAUSE_IN.wake && CAUSE_IN.wake_by_int && !CAUSE_IN.por &&
     !CAUSE_IN.ext_rst &&
     REGS_OUT[`RVI_IDX_CORE_INT_CONTROL][`RVI_GLB_INT_EN_BIT]) |=>
      PC_LOAD_OUT && PC_TARGET_OUT == `RVI_INT_VECTOR ##1
      // Strobes may follow back to back, so a second load needs a cause
      (PC_LOAD_OUT == $past(CAUSE_IN.por || CAUSE_IN.ext_rst ||
        (CAUSE_IN.wake && CAUSE_IN.wake_by_int &&
         REGS_OUT[`RVI_IDX_CORE_INT_CONTROL][`RVI_GLB_INT_EN_BIT])));
  endproperty
  a_int_vector: assert property (p_int_vector)
    else $error("interrupt vector not loaded on wake");

  property p_reserved_clear;
    !HAS_CONVERTER |->
      REGS_OUT[`RVI_IDX_PERIPH_INT_FLAGS][6] == 1'b0 &&
      REGS_OUT[`RVI_IDX_PERIPH_INT_ENABLES][6] == 1'b0;
  endproperty
  a_reserved_clear: assert property (p_reserved_clear)
    else $error("reserved peripheral bit set");

  property p_unimpl_zero;
    REGS_OUT[`RVI_IDX_CONVERTER_CONTROL_A][1] == 1'b0 &&
    REGS_OUT[`RVI_IDX_DISPLAY_CONTROL][5] == 1'b0 &&
    REGS_OUT[`RVI_IDX_TIMER_B_CONTROL][7] == 1'b0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented bit holds one");

  property p_apb_answer;
    (APB_REQ_IN.psel && APB_REQ_IN.penable && !APB_RSP_OUT.pready) |=>
      APB_RSP_OUT.pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer late");

  c_por: cover property (CAUSE_IN.por ##1 PC_LOAD_OUT);
  c_wake_vector: cover property (CAUSE_IN.wake && CAUSE_IN.wake_by_int
    ##1 (PC_LOAD_OUT && PC_TARGET_OUT == `RVI_INT_VECTOR));
  c_apb_write: cover property (wr_go);
  c_apb_error: cover property (APB_RSP_OUT.pready && APB_RSP_OUT.pslverr);

endmodule

// file: pkg/rvi_params.svh
`ifndef RVI_PARAMS_SVH
`define RVI_PARAMS_SVH

// Register indices; byte address is index * 4
`define RVI_IDX_PORT_D_LATCH 6'h00
`define RVI_IDX_PORT_E_LATCH 6'h01
`define RVI_IDX_PORT_F_LATCH 6'h02
`define RVI_IDX_PORT_G_LATCH 6'h03
`define RVI_IDX_PC_HIGH_LATCH 6'h04
`define RVI_IDX_CORE_INT_CONTROL 6'h05
`define RVI_IDX_PERIPH_INT_FLAGS 6'h06
`define RVI_IDX_PERIPH_INT_ENABLES 6'h07
`define RVI_IDX_TIMER_A_COUNT_LOW 6'h08
`define RVI_IDX_TIMER_A_COUNT_HIGH 6'h09
`define RVI_IDX_TIMER_A_CONTROL 6'h0A
`define RVI_IDX_TIMER_B_COUNT 6'h0B
`define RVI_IDX_TIMER_B_CONTROL 6'h0C
`define RVI_IDX_TIMER_B_PERIOD 6'h0D
`define RVI_IDX_CORE_OPTION 6'h0E
`define RVI_IDX_PORT_A_DIRECTION 6'h0F
`define RVI_IDX_PORT_B_DIRECTION 6'h10
`define RVI_IDX_PORT_C_DIRECTION 6'h11
`define RVI_IDX_PORT_D_DIRECTION 6'h12
`define RVI_IDX_PORT_E_DIRECTION 6'h13
`define RVI_IDX_PORT_F_DIRECTION 6'h14
`define RVI_IDX_PORT_G_DIRECTION 6'h15
`define RVI_IDX_SERIAL_PORT_CONTROL 6'h16
`define RVI_IDX_SERIAL_PORT_STATUS 6'h17
`define RVI_IDX_SERIAL_PORT_ADDRESS 6'h18
`define RVI_IDX_CAPCMP_CONTROL 6'h19
`define RVI_IDX_CONVERTER_CONTROL_A 6'h1A
`define RVI_IDX_CONVERTER_CONTROL_B 6'h1B
`define RVI_IDX_POWER_CONTROL_REG 6'h1C
`define RVI_IDX_DISPLAY_SEGMENT_ENABLE 6'h1D
`define RVI_IDX_DISPLAY_FRAME_PRESCALE 6'h1E
`define RVI_IDX_DISPLAY_CONTROL 6'h1F
`define RVI_IDX_RESET_CAUSE 6'h20
`define RVI_IDX_LAST 6'h20

// Implemented-bit masks
`define RVI_MASK_FULL 8'hFF
`define RVI_MASK_PC_HIGH 8'h1F
`define RVI_MASK_SIX 8'h3F
`define RVI_MASK_SEVEN 8'h7F
`define RVI_MASK_CONV_A 8'hFD
`define RVI_MASK_CONV_B 8'h07
`define RVI_MASK_POWER 8'h02
`define RVI_MASK_PRESCALE 8'h0F
`define RVI_MASK_DISPLAY 8'hDF
`define RVI_MASK_NO_CONV 8'hBF

// Reset values and vectors
`define RVI_VAL_ZERO 8'h00
`define RVI_VAL_ONES 8'hFF
`define RVI_GLB_INT_EN_BIT 7
`define RVI_RESET_VECTOR 13'h0000
`define RVI_INT_VECTOR 13'h0004

`endif

// file: pkg/rvi_pkg.sv
package rvi_pkg;

  typedef logic [7:0] rvi_byte_t;
  typedef rvi_byte_t [31:0] rvi_regs_t;

  typedef enum logic [1:0] {
    KIND_NORM,
    KIND_POR_ONLY,
    KIND_KEEP,
    KIND_FORCE
  } rvi_kind_e;

  typedef enum logic [1:0] {
    CAUSE_NONE,
    CAUSE_POR,
    CAUSE_EXT,
    CAUSE_WAKE
  } rvi_cause_e;

  typedef struct packed {
    rvi_byte_t mask;
    rvi_byte_t value;
    rvi_kind_e kind;
  } rvi_attr_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rvi_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rvi_apb_rsp_s;

  typedef struct packed {
    logic por;
    logic ext_rst;
    logic wake;
    logic wake_by_int;
    rvi_byte_t core_flags;
    rvi_byte_t periph_flags;
  } rvi_cause_in_s;

  typedef struct packed {
    rvi_regs_t regs;
    rvi_cause_e cause;
    rvi_apb_rsp_s rsp;
    logic pc_load;
    logic [12:0] pc_target;
  } rvi_state_s;

endpackage

// file: tb/rvi_reset_init_tb.sv
`timescale 1ns/1ps
module rvi_reset_init_tb;
  typedef struct packed {
    logic [31:0] d;
    logic e;
    logic c;
  } rvi_exp_s;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  rvi_pkg::rvi_cause_in_s cause = '0;
  rvi_pkg::rvi_apb_req_s req = '0;
  rvi_pkg::rvi_apb_rsp_s rsp;
  rvi_pkg::rvi_regs_t regs;
  logic pc_load;
  logic [12:0] pc_tgt;
  logic [7:0] m [0:31];
  logic [7:0] cause_m;
  rvi_exp_s apbq[$];
  logic [12:0] pcq[$];
  rvi_exp_s mon_x;
  rvi_pkg::rvi_cause_in_s cx;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;

  // Converter-less variant, so the reserved flag bit is exercised too
  rvi_reset_init #(.HAS_CONVERTER(1'b0)) u_rvi_reset_init (
    .MCLK_IN(mclk),
    .SRST_IN(srst),
    .CAUSE_IN(cause),
    .APB_REQ_IN(req),
    .APB_RSP_OUT(rsp),
    .REGS_OUT(regs),
    .PC_LOAD_OUT(pc_load),
    .PC_TARGET_OUT(pc_tgt)
  );

  always #20 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] msk(input logic [5:0] i);
    case (i)
      6'h04: msk = 8'h1F;
      6'h06, 6'h07: msk = 8'hBF;
      6'h0A, 6'h0F, 6'h11, 6'h19: msk = 8'h3F;
      6'h0C: msk = 8'h7F;
      6'h1A: msk = 8'hFD;
      6'h1B: msk = 8'h07;
      6'h1C: msk = 8'h02;
      6'h1E: msk = 8'h0F;
      6'h1F: msk = 8'hDF;
      default: msk = 8'hFF;
    endcase
  endfunction

  function automatic logic [7:0] rv(input logic [5:0] i);
    case (i)
      6'h0D, 6'h0E, 6'h10, 6'h12, 6'h13, 6'h14, 6'h15, 6'h1D: rv = 8'hFF;
      6'h0F, 6'h11: rv = 8'h3F;
      default: rv = 8'h00;
    endcase
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("Counts: %0d mismatches, %0d checks", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic reset_model();
    for (int k = 0; k < 32; k++) begin
      m[k] = rv(6'(k));
    end
    cause_m = 8'h00;
  endtask

  // Model of one strobe; por outranks ext_rst, which outranks wake
  task automatic apply(input rvi_pkg::rvi_cause_in_s c);
    logic [5:0] i;
    if (c.por || c.ext_rst) begin
      for (int k = 0; k < 32; k++) begin
        i = 6'(k);
        if (i == 6'h08 || i == 6'h09) begin
          m[k] = m[k];
        end else if (c.por) begin
          m[k] = rv(i);
        end else if (i == 6'h05) begin
          m[k] = m[k] & 8'h01;
        end else if (i != 6'h0A && i != 6'h1C) begin
          m[k] = rv(i);
        end
      end
      pcq.push_back(13'h0000);
      cause_m = c.por ? 8'h01 : 8'h02;
    end else if (c.wake) begin
      if (c.wake_by_int && m[5][7]) begin
        pcq.push_back(13'h0004);
      end
      m[13] = 8'hFF;
      m[5] = m[5] | c.core_flags;
      m[6] = m[6] | (c.periph_flags & 8'hBF);
      cause_m = 8'h03;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d, input bit drop);
    logic [5:0] i;
    logic [31:0] r;
    rvi_exp_s x;
    i = a[7:2];
    r = $urandom();
    x.e = (a[11:8] != 4'h0) || (a[1:0] != 2'h0) || (a[7:2] > 6'h20);
    x.c = !w;
    x.d = x.e ? 32'h0 : {24'h0, (i == 6'h20) ? cause_m : m[i[4:0]]};
    apbq.push_back(x);
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
             pwdata: {r[31:8], d}};
    @(posedge mclk);
    req.penable <= 1'b1;
    do @(posedge mclk); while (rsp.pready !== 1'b1);
    if (w && !x.e && i < 6'h20 && !drop) begin
      m[i[4:0]] = d & msk(i);
    end
    req <= '0;
  endtask

  task automatic check_all();
    for (int k = 0; k <= 32; k++) begin
      apb(1'b0, 12'(k * 4), 8'h00, 1'b0);
    end
    for (int k = 0; k < 32; k++) begin
      check({24'h0, regs[k]}, {24'h0, m[k]});
    end
  endtask

  task automatic rand_fill();
    for (int k = 0; k < 32; k++) begin
      apb(1'b1, 12'(k * 4), 8'($urandom()), 1'b0);
    end
  endtask

  function automatic rvi_pkg::rvi_cause_in_s mk(input int kind);
    rvi_pkg::rvi_cause_in_s c;
    c = '0;
    c.por = (kind == 1);
    c.ext_rst = (kind == 2);
    c.wake = (kind == 3);
    c.wake_by_int = 1'($urandom());
    c.core_flags = 8'($urandom());
    c.periph_flags = 8'($urandom());
    return c;
  endfunction

  task automatic send(input rvi_pkg::rvi_cause_in_s c);
    @(posedge mclk);
    cause <= c;
    apply(c);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (!srst && rsp.pready === 1'b1) begin
      if (apbq.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        mon_x = apbq.pop_front();
        check({31'h0, rsp.pslverr}, {31'h0, mon_x.e});
        if (mon_x.c) begin
          check(rsp.prdata, mon_x.d);
        end
      end
    end
  end

  // A load that no strobe asked for finds the queue empty
  always @(posedge mclk) begin
    if (!srst && pc_load === 1'b1) begin
      if (pcq.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        check({19'h0, pc_tgt}, {19'h0, pcq.pop_front()});
      end
    end
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    void'($urandom(10));
    reset_model();
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    check_all();
    rand_fill();
    check_all();
    // Back-to-back strobes of every cause after random contents
    for (int r = 0; r < 9; r++) begin
      rand_fill();
      if (r % 3 == 2) begin
        apb(1'b1, 12'h014, 8'h80, 1'b0);
      end
      // First round with the global enable set wakes by interrupt
      cx = mk(r % 3 + 1);
      cx.wake_by_int = cx.wake_by_int || (r == 2);
      send(cx);
      send(mk($urandom_range(1, 3)));
      @(posedge mclk);
      cause <= '0;
      check_all();
    end
    // Unmapped places, and the read-only cause word
    apb(1'b0, 12'h084, 8'h00, 1'b0);
    apb(1'b1, 12'h100, 8'h5A, 1'b0);
    apb(1'b0, 12'h102, 8'h00, 1'b0);
    apb(1'b1, 12'h081, 8'hA5, 1'b0);
    apb(1'b1, 12'h080, 8'hFF, 1'b0);
    check_all();
    // A write whose final edge meets a strobe is lost
    rand_fill();
    fork
      apb(1'b1, 12'h000, 8'hA5, 1'b1);
      begin
        repeat (3) @(posedge mclk);
        cx = mk(2);
        cause <= cx;
        apply(cx);
        @(posedge mclk);
        cause <= '0;
      end
    join
    check_all();
    // Reset again in mid-run
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    reset_model();
    @(posedge mclk);
    check_all();
    check(32'(pcq.size()), 32'h0);
    results();
  end
endmodule
